// [core_wrap.v]
// Processor wrapper: clock divide, tick, irq conditioning, vector checks, sleep.
// Assumes a free-running 48 MHz system clock on I_CLOCK and one block reset.
//
// Summary of operation
// - Processor clock enable divided by divider field
// - Tick rate is clock over 2*div+1
// - Trace strobe runs on undivided clock
// - Block reset holds all wrapper state
// - Interrupt inputs conditioned for any rate
// - Non-maskable interrupt tied inactive
// - Up to 240 interrupt lines accepted
// - Per-line pulse/level, mask and priority
// - Four-byte entries; entry zero is stack
// - Entry one reset; up to fifteen internal
// - Interrupt n fetches entry n plus 16
// - Table at most 256 entries, line 239
// - Vector loads halfword PC and state bit
// - Bit zero clear posts usage error
// - Faulty reset vector posts severe error
// - Exception numbers encoded per fixed table
// - Sleep deasserts clock request output
// - Clock request held unless all idle
// - Forced halt stops core, drops request
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "core_wrap_map.vh"
module core_wrap (
  input wire I_CLOCK,
  input wire I_RST,
  input wire [3:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  input wire [239:0] I_IRQ,
  input wire I_SLEEP_PERMIT,
  input wire I_FORCE_HALT,
  input wire I_DEBUG_IDLE,
  input wire I_CORE_SLEEP,
  input wire I_VEC_VALID,
  input wire [31:0] I_VEC_WORD,
  input wire I_DBG_EVENT,
  output reg O_CPU_CLK_EN,
  output reg O_TICK_EN,
  output reg O_TRACE_EN,
  output reg O_NMI,
  output reg O_IRQ_PENDING,
  output reg [7:0] O_IRQ_NUM,
  output reg [7:0] O_EXC_POST,
  output reg O_EXC_VALID,
  output reg O_INVALID_STATE,
  output reg [31:0] O_PC,
  output reg O_THUMB,
  output reg O_HALT,
  output reg O_CLK_REQ
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [8:0] irq_entry;
  input [7:0] n;
  begin
    irq_entry = {1'b0, n} + `VEC_IRQ_OFFSET;
  end
endfunction

function [31:0] entry_addr;
  input [31:0] base;
  input [8:0] ent;
  begin
    entry_addr = base + {21'h0, ent, 2'b00};
  end
endfunction

function [7:0] grp_lo;
  input [3:0] grp;
  begin
    grp_lo = {grp, 4'h0};
  end
endfunction

function [2:0] prio_of;
  input [719:0] p;
  input [7:0] n;
  begin
    prio_of = p[n*3 +: 3];
  end
endfunction

function is_vector;
  input [8:0] ent;
  begin
    is_vector = (ent != 9'h000) && (ent <= `VEC_MAX_ENTRY);
  end
endfunction

function core_exc;
  input [8:0] ent;
  begin
    core_exc = (ent != 9'h000) && (ent < `VEC_IRQ_OFFSET);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

// Software-visible settings
reg [7:0] clk_div_q;
reg [239:0] irq_level_q;
reg [239:0] irq_mask_q;
reg [719:0] prio_q;
reg [31:0] vec_base_q;
reg [8:0] vec_req_q;
reg dbg_mon_q;
reg [7:0] sel_idx_q;

// Rate counters
reg [7:0] div_cnt_q;
reg [8:0] tick_cnt_q;

// Interrupt path
reg [239:0] sync1_q;
reg [239:0] sync2_q;
reg [239:0] sync3_q;
reg [239:0] stretch_q;
reg [239:0] pend_q;
reg [7:0] req_idx_q;

// Combinational helpers
reg cpu_en_w;
reg [239:0] rise_w;
reg [239:0] act_w;
reg found_w;
reg [7:0] found_idx_w;
reg [2:0] best_prio_w;
reg [7:0] sel_w;
reg [8:0] entry_w;
reg [3:0] sel_grp_w;
reg [7:0] wr_line_w;
integer k;

// Priority writes name one line at a time; 48 bits per group do not fit a word
always @* begin
  wr_line_w = I_WDATA[15:8];
end

// One block reset holds everything
always @(posedge I_CLOCK or posedge I_RST) begin
  if (I_RST) begin
    clk_div_q <= `CLK_DIV_RST;
    irq_level_q <= 240'h0;
    irq_mask_q <= 240'h0;
    vec_base_q <= 32'h0;
    vec_req_q <= 9'h0;
    dbg_mon_q <= 1'b0;
    sel_idx_q <= 8'h0;
    prio_q <= 720'h0;
  end else begin
    if (I_WR) begin
      case (I_ADDR)
        `ADDR_CLK_DIV: clk_div_q <= I_WDATA[7:0];
        `ADDR_IRQ_MODE: irq_level_q[grp_lo(sel_grp_w) +: 16] <= I_WDATA[15:0];
        `ADDR_IRQ_MASK: irq_mask_q[grp_lo(sel_grp_w) +: 16] <= I_WDATA[15:0];
        `ADDR_VEC_BASE: vec_base_q <= {I_WDATA[31:10], 10'h000};
        `ADDR_VEC_REQ: vec_req_q <= I_WDATA[8:0];
        `ADDR_IRQ_PRIO: begin
          if (wr_line_w < `IRQ_N)
            prio_q[wr_line_w*3 +: 3] <= I_WDATA[2:0];
        end
        `ADDR_SLEEP: begin
          dbg_mon_q <= I_WDATA[0];
          if (I_WDATA[11:4] < 8'd15)
            sel_idx_q <= I_WDATA[11:4];
        end
        default: clk_div_q <= clk_div_q;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Clock enables

always @* begin
  cpu_en_w = (div_cnt_q == 8'h00);
end

always @(posedge I_CLOCK or posedge I_RST) begin
  if (I_RST) begin
    div_cnt_q <= 8'h0;
    tick_cnt_q <= 9'h0;
    O_CPU_CLK_EN <= 1'b0;
    O_TICK_EN <= 1'b0;
    O_TRACE_EN <= 1'b0;
    O_NMI <= 1'b0;
  end else begin
    // A divider lowered mid-count wraps at once; the next period is exact
    div_cnt_q <= (div_cnt_q >= clk_div_q) ? 8'h0 : div_cnt_q + 8'h1;
    O_CPU_CLK_EN <= cpu_en_w;
    // Tick period is 2*div+1 system clocks
    if (tick_cnt_q >= {clk_div_q, 1'b0}) begin
      tick_cnt_q <= 9'h0;
      O_TICK_EN <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 9'h1;
      O_TICK_EN <= 1'b0;
    end
    O_TRACE_EN <= 1'b1;
    O_NMI <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt conditioning
// Short pulses are stretched until the divided clock samples them, so a
// slow core clock cannot miss an edge; the wait is at most one core cycle, as for a level.

always @* begin
  rise_w = sync2_q & ~sync3_q;
  act_w = pend_q & irq_mask_q;
end

always @(posedge I_CLOCK or posedge I_RST) begin
  if (I_RST) begin
    sync1_q <= 240'h0;
    sync2_q <= 240'h0;
    sync3_q <= 240'h0;
    stretch_q <= 240'h0;
    pend_q <= 240'h0;
  end else begin
    sync1_q <= I_IRQ;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
    // Set wins over the sampling clear
    stretch_q <= rise_w | (stretch_q & ~{240{cpu_en_w}});
    if (cpu_en_w)
      pend_q <= (irq_level_q & sync2_q) | (~irq_level_q & (stretch_q | rise_w));
  end
end

// All 240 lines scanned
// Lower priority value is more urgent; the strict compare keeps the
// lowest line number on a tie
always @* begin
  found_w = 1'b0;
  found_idx_w = 8'h0;
  best_prio_w = 3'h7;
  for (k = 0; k < `IRQ_N; k = k + 1) begin
    if (act_w[k] && (!found_w || prio_of(prio_q, k[7:0]) < best_prio_w)) begin
      found_w = 1'b1;
      found_idx_w = k[7:0];
      best_prio_w = prio_of(prio_q, k[7:0]);
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Vector fetch check

always @* begin
  sel_grp_w = sel_idx_q[3:0];
  sel_w = found_idx_w;
  entry_w = irq_entry(sel_w);
end

always @(posedge I_CLOCK or posedge I_RST) begin
  if (I_RST) begin
    O_IRQ_PENDING <= 1'b0;
    O_IRQ_NUM <= 8'h0;
    req_idx_q <= 8'h0;
    O_EXC_POST <= 8'h0;
    O_EXC_VALID <= 1'b0;
    O_INVALID_STATE <= 1'b0;
    O_PC <= 32'h0;
    O_THUMB <= 1'b0;
  end else begin
    O_IRQ_PENDING <= found_w;
    O_IRQ_NUM <= entry_w[7:0];
    // Winner stays put while idle so software can still read its entry
    if (found_w)
      req_idx_q <= sel_w;
    O_EXC_VALID <= 1'b0;
    if (I_DBG_EVENT && dbg_mon_q) begin
      O_EXC_POST <= `EXC_DBGMON;
      O_EXC_VALID <= 1'b1;
    end

    // Entry zero is stack pointer, never a vector
    if (I_VEC_VALID && is_vector(vec_req_q)) begin
      O_PC <= {I_VEC_WORD[31:1], 1'b0};
      O_THUMB <= I_VEC_WORD[0];
      // Posted numbers come from the fixed exception table
      if (!I_VEC_WORD[0]) begin
        O_EXC_VALID <= 1'b1;
        if (vec_req_q == `VEC_RESET_ENTRY) begin
          O_EXC_POST <= `EXC_SEVERE;
          O_INVALID_STATE <= 1'b0;
        end else begin
          O_EXC_POST <= `EXC_USAGE;
          O_INVALID_STATE <= 1'b1;
        end
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Sleep handshake
// Debug idle is a pin; sleep permit and halt likewise, so all are synced.

reg [2:0] slp_s1_q;
reg [2:0] slp_s2_q;
reg idle_w;

// Core sleep comes from the core on this clock, so it is not synced
always @* begin
  idle_w = !found_w && slp_s2_q[1] && slp_s2_q[0];
end

always @(posedge I_CLOCK or posedge I_RST) begin
  if (I_RST) begin
    slp_s1_q <= 3'h0;
    slp_s2_q <= 3'h0;
    O_HALT <= 1'b0;
    O_CLK_REQ <= 1'b1;
  end else begin
    slp_s1_q <= {I_FORCE_HALT, I_SLEEP_PERMIT, I_DEBUG_IDLE};
    slp_s2_q <= slp_s1_q;
    O_HALT <= slp_s2_q[2];
    if (slp_s2_q[2])
      O_CLK_REQ <= 1'b0;
    else if (!idle_w)
      O_CLK_REQ <= 1'b1;
    else
      O_CLK_REQ <= ~I_CORE_SLEEP;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register read

always @(posedge I_CLOCK or posedge I_RST) begin
  if (I_RST) begin
    O_RDATA <= 32'h0;
  end else if (I_RD) begin
    case (I_ADDR)
      `ADDR_CLK_DIV: O_RDATA <= {24'h0, clk_div_q};
      `ADDR_IRQ_MODE: O_RDATA <= {16'h0, irq_level_q[grp_lo(sel_grp_w) +: 16]};
      `ADDR_IRQ_MASK: O_RDATA <= {16'h0, irq_mask_q[grp_lo(sel_grp_w) +: 16]};
      `ADDR_VEC_BASE: O_RDATA <= vec_base_q;
      `ADDR_VEC_REQ: O_RDATA <= {23'h0, vec_req_q};
      `ADDR_VEC_RES: O_RDATA <= entry_addr(vec_base_q, irq_entry(req_idx_q));
      `ADDR_STATUS: O_RDATA <= {14'h0, core_exc(vec_req_q), O_INVALID_STATE, O_EXC_POST, req_idx_q};
      `ADDR_SLEEP: O_RDATA <= {20'h0, sel_idx_q, 3'h0, dbg_mon_q};
      `ADDR_IRQ_PEND: O_RDATA <= {16'h0, pend_q[grp_lo(sel_grp_w) +: 16]};
      `ADDR_IRQ_PRIO: O_RDATA <= {29'h0, prio_of(prio_q, req_idx_q)};
      // Unmapped offsets read as zero
      default: O_RDATA <= 32'h0;
    endcase
  end
end

endmodule // core_wrap

// [core_wrap_map.vh]
// Constants for the processor wrapper: divider, tick, vector table, exceptions.
// Assumes inclusion by the wrapper, its checker and its testbench; definitions only.
`ifndef CORE_WRAP_MAP_VH
`define CORE_WRAP_MAP_VH
// Register offsets (word addresses on the plain register port)
`define ADDR_CLK_DIV 4'h0
`define ADDR_IRQ_MODE 4'h1
`define ADDR_IRQ_MASK 4'h2
`define ADDR_VEC_BASE 4'h3
`define ADDR_VEC_REQ 4'h4
`define ADDR_VEC_RES 4'h5
`define ADDR_STATUS 4'h6
`define ADDR_SLEEP 4'h7
`define ADDR_IRQ_PEND 4'h8
`define ADDR_IRQ_PRIO 4'h9
// Field positions and widths
`define CLK_DIV_W 8
`define IRQ_N 240
`define IRQ_IDX_W 8
`define PRIO_W 3
`define CLK_DIV_RST 8'h00
// Vector table
`define VEC_ENTRY_BYTES 32'h4
`define VEC_IRQ_OFFSET 9'h010
`define VEC_MAX_ENTRY 9'h0ff
`define VEC_RESET_ENTRY 9'h001
// Exception numbers
`define EXC_NMI 8'h02
`define EXC_SEVERE 8'h03
`define EXC_MEMMGMT 8'h04
`define EXC_BUSERR 8'h05
`define EXC_USAGE 8'h06
`define EXC_SVC 8'h0b
`define EXC_DBGMON 8'h0c
`define EXC_PENDABLE_SERVICE_EXCEPTION 8'h0e
`define EXC_SYSTEM_TICK_EXCEPTION 8'h0f
`endif

// [core_wrap_props.sv]
// Checker on the wrapper ports: vector checks, clock request, tie-offs.
// Assumes the wrapper's own top ports; bound after the module.
`timescale 1ns/100ps
`include "core_wrap_map.vh"
module core_wrap_props (
  input wire I_CLOCK,
  input wire I_RST,
  input wire I_VEC_VALID,
  input wire [31:0] I_VEC_WORD,
  input wire I_DBG_EVENT,
  input wire I_SLEEP_PERMIT,
  input wire I_FORCE_HALT,
  input wire I_DEBUG_IDLE,
  input wire I_CORE_SLEEP,
  input wire O_TRACE_EN,
  input wire O_NMI,
  input wire O_IRQ_PENDING,
  input wire [7:0] O_EXC_POST,
  input wire O_EXC_VALID,
  input wire O_INVALID_STATE,
  input wire [31:0] O_PC,
  input wire O_THUMB,
  input wire O_HALT,
  input wire O_CLK_REQ
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // Eight cycles cover the two-stage sync plus the request update
  sequence halt_held; I_FORCE_HALT [*8]; endsequence
  sequence all_idle;
    (I_CORE_SLEEP && I_SLEEP_PERMIT && I_DEBUG_IDLE && !O_IRQ_PENDING) [*8];
  endsequence
  sequence awake; (!I_SLEEP_PERMIT && !I_FORCE_HALT) [*8]; endsequence
  nmi_tied_a: assert property (!O_NMI) else $error("nmi raised");
  trace_on_a: assert property ($past(!I_RST, 2) |-> O_TRACE_EN) else $error("trace");
  pc_load_a: assert property (I_VEC_VALID |=> O_THUMB == $past(I_VEC_WORD[0]) &&
    O_PC == {$past(I_VEC_WORD[31:1]), 1'b0}) else $error("pc load");
  bad_state_a: assert property (I_VEC_VALID && !I_VEC_WORD[0] |=> O_EXC_VALID &&
    (O_INVALID_STATE || O_EXC_POST == `EXC_SEVERE)) else $error("bad state");
  good_vec_a: assert property (I_VEC_VALID && I_VEC_WORD[0] && !I_DBG_EVENT |=> !O_EXC_VALID)
    else $error("vec");
  halt_drop_a: assert property (halt_held |-> !O_CLK_REQ && O_HALT) else $error("halt");
  req_hold_a: assert property (awake |-> O_CLK_REQ) else $error("req hold");
  sleep_drop_a: assert property (all_idle |-> !O_CLK_REQ) else $error("sleep");
endmodule // core_wrap_props
bind core_wrap core_wrap_props core_wrap_props_inst (.*);

// [chip_side_model.sv]
// Chip-side partner: presents fetched vector words and debug events.
// Assumes one clock shared with the wrapper; driven by test task calls.
`timescale 1ns/100ps
module chip_side_model (
  input wire i_clock,
  output reg o_vec_valid = 1'b0,
  output reg [31:0] o_vec_word = 32'h0,
  output reg o_dbg_event = 1'b0
);
  // Answer after a chosen wait; table sizing is the caller's job
  // A debug hit goes to the monitor path, not a halt
  task drive(input dbg, input [31:0] w, input integer wait_n);
    begin
      repeat (wait_n + 1) @(posedge i_clock);
      o_dbg_event <= dbg;
      o_vec_valid <= !dbg;
      o_vec_word <= w;
      @(posedge i_clock);
      o_dbg_event <= 1'b0;
      o_vec_valid <= 1'b0;
      // Stale word flipped so a late sample shows up
      o_vec_word <= ~w;
    end
  endtask
endmodule // chip_side_model

// [test_core_wrap.sv]
// Testbench: register port, irq lines, vector fetch and sleep handshake.
// Assumes the chip-side model and the bound checker beside the wrapper.
`timescale 1ns/100ps
`include "core_wrap_map.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_core_wrap;
  reg I_CLOCK = 1'b0, I_RST = 1'b1, I_WR = 1'b0, I_RD = 1'b0, I_DEBUG_IDLE = 1'b0;
  reg I_SLEEP_PERMIT = 1'b0, I_FORCE_HALT = 1'b0, I_CORE_SLEEP = 1'b0;
  reg [3:0] I_ADDR = 4'h0;
  reg [31:0] I_WDATA = 32'h0, v;
  reg [239:0] I_IRQ = 240'h0;
  wire I_VEC_VALID, I_DBG_EVENT, O_CPU_CLK_EN, O_TICK_EN, O_TRACE_EN, O_NMI;
  wire O_IRQ_PENDING, O_EXC_VALID, O_INVALID_STATE, O_THUMB, O_HALT, O_CLK_REQ;
  wire [31:0] O_RDATA, I_VEC_WORD, O_PC;
  wire [7:0] O_IRQ_NUM, O_EXC_POST;
  integer error_cnt = 0, tests_run = 0, cyc = 0, n, nt, nc;
  always #20 I_CLOCK = ~I_CLOCK;
  core_wrap core_wrap_inst (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_IRQ(I_IRQ),
    .I_SLEEP_PERMIT(I_SLEEP_PERMIT), .I_FORCE_HALT(I_FORCE_HALT),
    .I_DEBUG_IDLE(I_DEBUG_IDLE), .I_CORE_SLEEP(I_CORE_SLEEP), .I_VEC_VALID(I_VEC_VALID),
    .I_VEC_WORD(I_VEC_WORD), .I_DBG_EVENT(I_DBG_EVENT), .O_CPU_CLK_EN(O_CPU_CLK_EN),
    .O_TICK_EN(O_TICK_EN), .O_TRACE_EN(O_TRACE_EN), .O_NMI(O_NMI),
    .O_IRQ_PENDING(O_IRQ_PENDING), .O_IRQ_NUM(O_IRQ_NUM), .O_EXC_POST(O_EXC_POST),
    .O_EXC_VALID(O_EXC_VALID), .O_INVALID_STATE(O_INVALID_STATE), .O_PC(O_PC),
    .O_THUMB(O_THUMB), .O_HALT(O_HALT), .O_CLK_REQ(O_CLK_REQ));
  chip_side_model chip_side_model_inst (.i_clock(I_CLOCK), .o_vec_valid(I_VEC_VALID),
    .o_vec_word(I_VEC_WORD), .o_dbg_event(I_DBG_EVENT));
  always @(posedge I_CLOCK) begin
    nt = nt + O_TICK_EN;
    nc = nc + O_CPU_CLK_EN;
    cyc = cyc + 1;
    if (cyc > 20000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge I_CLOCK);
      I_ADDR <= a;
      I_WDATA <= d;
      I_WR <= w;
      I_RD <= !w;
      @(posedge I_CLOCK);
      I_WR <= 1'b0;
      I_RD <= 1'b0;
      // Read data stand in the cycle after the strobe; take them at its end
      @(posedge I_CLOCK);
      v = O_RDATA;
    end
  endtask
  task irq_try(input integer ln, input en, input lvl, input [7:0] e);
    begin
      bus(1, `ADDR_SLEEP, (ln / 16) << 4);
      bus(1, `ADDR_IRQ_MASK, {31'h0, en} << (ln % 16));
      bus(1, `ADDR_IRQ_MODE, {32{lvl}});
      I_IRQ[ln] <= 1'b1;
      @(posedge I_CLOCK) I_IRQ[ln] <= lvl;
      for (n = 0; n < 20 && O_IRQ_PENDING !== 1'b1; n = n + 1) @(posedge I_CLOCK);
      `CHK(O_IRQ_PENDING, en)
      if (en) `CHK(O_IRQ_NUM, e)
      I_IRQ[ln] <= 1'b0;
      repeat (12) @(posedge I_CLOCK);
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    #1 `CHK({O_CLK_REQ, O_PC}, {1'b1, 32'h0})
    bus(1, `ADDR_CLK_DIV, 32'h3);
    bus(0, `ADDR_CLK_DIV, 32'h0);
    `CHK(v, 32'h3)
    bus(0, 4'hf, 32'h0);
    `CHK(v, 32'h0)
    #1 nt = 0;
    nc = 0;
    // 28 cycles hold whole periods of both enables at a divider of three
    repeat (28) @(posedge I_CLOCK);
    #1 `CHK(nc, 7)
    `CHK(nt, 4)
    `CHK({O_TRACE_EN, O_NMI}, 2'b10)
    $display("done: clocks");
    bus(1, `ADDR_VEC_BASE, 32'h400);
    bus(1, `ADDR_IRQ_PRIO, 32'h2505);
    irq_try(37, 1'b1, 1'b1, 8'h35);
    bus(0, `ADDR_IRQ_PRIO, 32'h0);
    `CHK(v, 32'h5)
    irq_try(239, 1'b1, 1'b1, 8'hff);
    bus(0, `ADDR_VEC_RES, 32'h0);
    `CHK(v, 32'h7fc)
    irq_try(38, 1'b0, 1'b1, 8'h0);
    $display("done: irq");
    bus(1, `ADDR_VEC_REQ, 32'h10);
    chip_side_model_inst.drive(1'b0, 32'h1235, 0);
    #1 `CHK({O_PC, O_THUMB, O_EXC_VALID}, {32'h1234, 2'b10})
    chip_side_model_inst.drive(1'b0, 32'h2000, 3);
    #1 `CHK({O_EXC_VALID, O_EXC_POST, O_INVALID_STATE}, {1'b1, `EXC_USAGE, 1'b1})
    bus(1, `ADDR_VEC_REQ, 32'h1);
    chip_side_model_inst.drive(1'b0, 32'h100, 0);
    #1 `CHK({O_EXC_VALID, O_EXC_POST}, {1'b1, `EXC_SEVERE})
    bus(1, `ADDR_SLEEP, 32'h1);
    chip_side_model_inst.drive(1'b1, 32'h0, 0);
    #1 for (n = 0; n < 5 && O_EXC_VALID !== 1'b1; n = n + 1) @(posedge I_CLOCK) #1;
    `CHK(O_EXC_POST, `EXC_DBGMON)
    $display("done: vectors");
    @(posedge I_CLOCK) I_CORE_SLEEP <= 1'b1;
    I_SLEEP_PERMIT <= 1'b1;
    I_DEBUG_IDLE <= 1'b1;
    repeat (10) @(posedge I_CLOCK);
    `CHK(O_CLK_REQ, 1'b0)
    I_SLEEP_PERMIT <= 1'b0;
    repeat (10) @(posedge I_CLOCK);
    `CHK(O_CLK_REQ, 1'b1)
    I_FORCE_HALT <= 1'b1;
    repeat (10) @(posedge I_CLOCK);
    `CHK({O_CLK_REQ, O_HALT}, 2'b01)
    I_FORCE_HALT <= 1'b0;
    // A one-cycle pulse is shorter than the divided clock and must still land
    irq_try(0, 1'b1, 1'b0, 8'h10);
    $display("done: sleep and pulse");
    wrap_up;
  end
endmodule // test_core_wrap
